/* camtop_ctrl.sv */
// camtop_ctrl: capture top control, pattern replay sequencer and input routing
// assumes: one 200 mhz clock, synchronous active-low reset, avalon-mm slave
// Contract
// - enable bit low holds whole capture subsystem in reset and disabled
// - pattern replays repeat-count field plus one times
// - software sets start bit; hardware clears it after all repeats
// - function-enable bit switches pattern generation on or off
// - output-port code 000 routes pattern to serial camera port zero
// - width code 00 gives 8-bit samples, 01 gives 10-bit samples
// - lane-mode codes 0000 to 0011 select one to four lanes
// - generator working clock is divided per the 2-bit divider field
// - wait delay-field clocks after start before generating; resets to 0xF
// - pattern size in bytes comes from full 32-bit length register
// - pattern fetched from the 32-bit pattern address register
// - frame height and width apply only in image-processor mode
// - input0 takes parser channel 0 on 000, channel 1 on 100
// - inputs one to three take parser channels one to three on 000
// - post-processor zero takes processor channel 0 on 000
// - post-processor one takes channel 0 on 000, channel 1 on 010
`timescale 1ns/1ps
`default_nettype none
module camtop_ctrl
    import camtop_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm register slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // subsystem control
    output logic             subsys_rst_n,
    // pattern memory fetch and generator controls
    output logic             ptn_fetch_req,
    output logic      [31:0] ptn_fetch_addr,
    input  wire logic        ptn_fetch_ack,
    output logic             ptn_active,
    output logic             ptn_gen_tick,
    output logic             ptn_to_serial0,
    output logic      [2:0]  ptn_lane_count,
    output logic             ptn_sample_10bit,
    output logic      [12:0] ptn_frame_width,
    output logic      [12:0] ptn_frame_height,
    input  wire logic        ptn_proc_mode,
    // routing selects, one-hot per source
    output logic      [1:0]  proc0_src,
    output logic      [2:0]  proc123_src_ok,
    output logic             post0_src_ok,
    output logic      [1:0]  post1_src
);

    // ********************************
    // state
    // ********************************
    typedef enum logic [1:0] {PG_IDLE, PG_DELAY, PG_RUN} camtop_pg_t;

    typedef struct packed {
        logic        top_en;
        logic        func_en;
        logic        run_req;
        logic [7:0]  repeat_cnt;
        logic [31:0] ctrl;
        logic [31:0] len;
        logic [31:0] addr;
        logic [31:0] frame;
        logic [2:0]  sel_in0;
        logic [2:0]  sel_in1;
        logic [2:0]  sel_in2;
        logic [2:0]  sel_in3;
        logic [2:0]  sel_pp0;
        logic [2:0]  sel_pp1;
        logic [1:0]  pg;
        logic [7:0]  dly_cnt;
        logic [7:0]  rep_done;
        logic [31:0] byte_cnt;
        logic [3:0]  div_cnt;
        logic        tick;
        logic        fetch_req;
        logic [31:0] fetch_addr;
        logic        waitreq;
        logic [31:0] rdata;
    } camtop_st_t;

    camtop_st_t st_ff;
    camtop_st_t nxt_st;

    // bytes moved per acknowledged fetch: one per lane
    function automatic logic [31:0] camtop_lanes(input logic [3:0] mode);
        camtop_lanes = (mode <= LANE_MAX_CODE) ? {28'h0, mode} + 32'h1 : 32'h1;
    endfunction

    // byte-lane merge for a 32-bit register write
    function automatic logic [31:0] camtop_merge(input logic [31:0] old,
                                                 input logic [31:0] wd,
                                                 input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            camtop_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    camtop_pg_t  pg_now;
    logic        acc;
    logic [31:0] wv;
    logic [31:0] rv;
    logic [3:0]  div_max;
    logic [31:0] step;

    always_comb begin
        pg_now  = camtop_pg_t'(st_ff.pg);
        div_max = 4'h1 << st_ff.ctrl[POS_CLKDIV_LO +: 2];
        step    = camtop_lanes(st_ff.ctrl[POS_LANE_LO +: 4]);
    end

    // ********************************
    // next-state logic
    // ********************************
    always_comb begin
        nxt_st = st_ff;
        acc    = (avs_read || avs_write) && st_ff.waitreq;
        wv     = 32'h0;
        rv     = BUS_UNMAPPED;
        // bus: one wait cycle, answer on the second edge
        nxt_st.waitreq = 1'b1;
        if (acc) begin
            nxt_st.waitreq = 1'b0;
        end
        // divider runs freely during a run so ticks stay evenly spaced;
        // a tick that meets a pending fetch is simply skipped
        nxt_st.tick = 1'b0;
        if (pg_now == PG_RUN) begin
            if (st_ff.div_cnt + 4'h1 >= div_max) begin
                nxt_st.div_cnt = 4'h0;
                nxt_st.tick    = 1'b1;
            end else begin
                nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
            end
        end
        // sequencer
        unique case (pg_now)
            PG_IDLE: begin
                if (st_ff.run_req && st_ff.func_en) begin
                    nxt_st.pg       = PG_DELAY;
                    nxt_st.div_cnt  = 4'h0;
                    nxt_st.dly_cnt  = st_ff.ctrl[POS_DELAY_LO +: 8];
                    nxt_st.rep_done = 8'h0;
                    nxt_st.byte_cnt = 32'h0;
                end
            end
            PG_DELAY: begin
                if (st_ff.dly_cnt == 8'h0) begin
                    nxt_st.pg = PG_RUN;
                end else begin
                    nxt_st.dly_cnt = st_ff.dly_cnt - 8'h1;
                end
            end
            PG_RUN: begin
                // each tick with no fetch pending asks memory for the next chunk
                if (st_ff.tick && !st_ff.fetch_req) begin
                    nxt_st.fetch_req  = 1'b1;
                    nxt_st.fetch_addr = st_ff.addr + st_ff.byte_cnt;
                end
                if (st_ff.fetch_req && ptn_fetch_ack) begin
                    nxt_st.fetch_req = 1'b0;
                    if (st_ff.byte_cnt + step >= st_ff.len) begin
                        nxt_st.byte_cnt = 32'h0;
                        if (st_ff.rep_done == st_ff.repeat_cnt) begin
                            nxt_st.pg      = PG_IDLE;
                            nxt_st.run_req = 1'b0;
                        end else begin
                            nxt_st.rep_done = st_ff.rep_done + 8'h1;
                        end
                    end else begin
                        nxt_st.byte_cnt = st_ff.byte_cnt + step;
                    end
                end
            end
        endcase
        // function disable aborts a run
        if (!st_ff.func_en && pg_now != PG_IDLE) begin
            nxt_st.pg        = PG_IDLE;
            nxt_st.fetch_req = 1'b0;
            nxt_st.run_req   = 1'b0;
        end
        // register reads
        unique case (avs_address)
            OFF_TOP_ENABLE:   rv = {31'h0, st_ff.top_en};
            OFF_PTN_EN_START: rv = {8'h0, st_ff.repeat_cnt, 11'h0, st_ff.run_req,
                                    3'h0, st_ff.func_en};
            OFF_PTN_CONTROL:  rv = st_ff.ctrl;
            OFF_PTN_LENGTH:   rv = st_ff.len;
            OFF_PTN_ADDRESS:  rv = st_ff.addr;
            OFF_PTN_FRAME:    rv = st_ff.frame;
            OFF_PROC_IN0:     rv = {29'h0, st_ff.sel_in0};
            OFF_PROC_IN1:     rv = {29'h0, st_ff.sel_in1};
            OFF_PROC_IN2:     rv = {29'h0, st_ff.sel_in2};
            OFF_PROC_IN3:     rv = {29'h0, st_ff.sel_in3};
            OFF_POST0_IN:     rv = {29'h0, st_ff.sel_pp0};
            OFF_POST1_IN:     rv = {29'h0, st_ff.sel_pp1};
            OFF_PTN_STATUS:   rv = {22'h0, st_ff.pg, st_ff.rep_done};
            default:          rv = BUS_UNMAPPED;
        endcase
        if (acc && avs_read) begin
            nxt_st.rdata = rv;
        end
        // register writes; software start wins over no-op, hw clear above
        if (acc && avs_write) begin
            wv = camtop_merge(rv, avs_writedata, avs_byteenable);
            unique case (avs_address)
                OFF_TOP_ENABLE:   nxt_st.top_en = wv[0];
                OFF_PTN_EN_START: begin
                    nxt_st.func_en    = wv[POS_FUNC_EN];
                    nxt_st.repeat_cnt = wv[POS_REPEAT_LO +: 8];
                    if (wv[POS_RUN_REQ]) begin
                        nxt_st.run_req = 1'b1;
                    end
                end
                OFF_PTN_CONTROL:  nxt_st.ctrl  = wv & 32'h073F03FF;
                OFF_PTN_LENGTH:   nxt_st.len   = wv;
                OFF_PTN_ADDRESS:  nxt_st.addr  = wv;
                OFF_PTN_FRAME:    nxt_st.frame = wv & 32'h1FFF1FFF;
                OFF_PROC_IN0:     nxt_st.sel_in0 = wv[2:0];
                OFF_PROC_IN1:     nxt_st.sel_in1 = wv[2:0];
                OFF_PROC_IN2:     nxt_st.sel_in2 = wv[2:0];
                OFF_PROC_IN3:     nxt_st.sel_in3 = wv[2:0];
                OFF_POST0_IN:     nxt_st.sel_pp0 = wv[2:0];
                OFF_POST1_IN:     nxt_st.sel_pp1 = wv[2:0];
                default:          nxt_st.top_en  = st_ff.top_en;
            endcase
        end
        // top enable low holds the pattern sequencer idle and clears function and start bits
        if (!st_ff.top_en) begin
            nxt_st.func_en  = 1'b0;
            nxt_st.run_req  = 1'b0;
            nxt_st.pg       = 2'(PG_IDLE);
            nxt_st.fetch_req = 1'b0;
            nxt_st.div_cnt  = 4'h0;
            nxt_st.tick     = 1'b0;
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff         <= '0;
            st_ff.ctrl    <= RST_PTN_CONTROL;
            st_ff.waitreq <= 1'b1;
            st_ff.pg      <= 2'(PG_IDLE);
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************************
    // outputs, all from flops
    // ********************************
    logic [1:0]  proc0_ff;
    logic [2:0]  p123_ff;
    logic        pp0_ff;
    logic [1:0]  pp1_ff;
    logic        serial0_ff;
    logic [2:0]  lanes_ff;
    logic        w10_ff;
    logic [25:0] frm_ff;
    logic        srst_ff;

    // decode routing one cycle late; reserved codes connect nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            proc0_ff   <= 2'h0;
            p123_ff    <= 3'h0;
            pp0_ff     <= 1'b0;
            pp1_ff     <= 2'h0;
            serial0_ff <= 1'b0;
            lanes_ff   <= 3'h0;
            w10_ff     <= 1'b0;
            frm_ff     <= 26'h0;
            srst_ff    <= 1'b0;
        end else begin
            srst_ff    <= st_ff.top_en;
            proc0_ff   <= {st_ff.top_en && st_ff.sel_in0 == SEL_CODE_100,
                           st_ff.top_en && st_ff.sel_in0 == SEL_CODE_000};
            p123_ff    <= {st_ff.top_en && st_ff.sel_in3 == SEL_CODE_000,
                           st_ff.top_en && st_ff.sel_in2 == SEL_CODE_000,
                           st_ff.top_en && st_ff.sel_in1 == SEL_CODE_000};
            pp0_ff     <= st_ff.top_en && st_ff.sel_pp0 == SEL_CODE_000;
            pp1_ff     <= {st_ff.top_en && st_ff.sel_pp1 == SEL_CODE_010,
                           st_ff.top_en && st_ff.sel_pp1 == SEL_CODE_000};
            serial0_ff <= st_ff.ctrl[POS_PORT_LO +: 3] == PORT_SERIAL0;
            lanes_ff   <= 3'(step);
            w10_ff     <= st_ff.ctrl[POS_WIDTH_LO +: 2] == WIDTH_10BIT;
            // frame size only passes through in processor mode
            frm_ff     <= ptn_proc_mode ? {st_ff.frame[POS_FRM_H_LO +: 13],
                                           st_ff.frame[POS_FRM_W_LO +: 13]} : 26'h0;
        end
    end

    assign avs_readdata     = st_ff.rdata;
    assign avs_waitrequest  = st_ff.waitreq;
    assign subsys_rst_n     = srst_ff;
    assign ptn_fetch_req    = st_ff.fetch_req;
    assign ptn_fetch_addr   = st_ff.fetch_addr;
    assign ptn_active       = st_ff.pg != 2'(PG_IDLE);
    assign ptn_gen_tick     = st_ff.tick;
    assign ptn_to_serial0   = serial0_ff;
    assign ptn_lane_count   = lanes_ff;
    assign ptn_sample_10bit = w10_ff;
    assign ptn_frame_height = frm_ff[25:13];
    assign ptn_frame_width  = frm_ff[12:0];
    assign proc0_src        = proc0_ff;
    assign proc123_src_ok   = p123_ff;
    assign post0_src_ok     = pp0_ff;
    assign post1_src        = pp1_ff;

    // ********************************
    // checks
    // ********************************
    chk_enable_holds: assert property (@(posedge clk) disable iff (!rst_n)
        !st_ff.top_en |=> !ptn_active && !ptn_fetch_req)
        else $error("pattern active while top disabled");
    chk_run_clears: assert property (@(posedge clk) disable iff (!rst_n)
        ptn_active && !nxt_st.run_req |=> !ptn_active)
        else $error("start bit cleared while run continues");
    chk_func_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !st_ff.func_en && !ptn_active |=> !ptn_active)
        else $error("run started with function disabled");
    chk_delay_start: assert property (@(posedge clk) disable iff (!rst_n)
        pg_now == PG_IDLE && nxt_st.pg == 2'(PG_DELAY) |=>
        st_ff.dly_cnt == st_ff.ctrl[7:0])
        else $error("start delay not loaded");
    chk_repeat_end: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(ptn_active) && st_ff.top_en && st_ff.func_en |->
        $past(st_ff.rep_done) == st_ff.repeat_cnt)
        else $error("run ended before repeat count");
    chk_run_reads: assert property (@(posedge clk) disable iff (!rst_n)
        ptn_active |-> st_ff.run_req)
        else $error("start bit low during a run");
    chk_route_in0: assert property (@(posedge clk) disable iff (!rst_n)
        st_ff.top_en && st_ff.sel_in0 == SEL_CODE_100 |=> proc0_src == 2'h2)
        else $error("input0 routing wrong");
    chk_route_pp1: assert property (@(posedge clk) disable iff (!rst_n)
        st_ff.top_en && st_ff.sel_pp1 == SEL_CODE_010 |=> post1_src == 2'h2)
        else $error("post1 routing wrong");
    chk_fetch_addr: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ptn_fetch_req) |-> ptn_fetch_addr == st_ff.addr + st_ff.byte_cnt)
        else $error("fetch address wrong");
endmodule
`default_nettype wire

/* camtop_ctrl_tb.sv */
// camtop_ctrl_tb: self-checking bench for the capture top control block
// assumes: camtop_pkg, camtop_ctrl and camtop_mem_model compiled first
`timescale 1ns/1ps
`default_nettype none
module camtop_ctrl_tb;
    import camtop_pkg::*;
    // ********************************
    // signals and bookkeeping
    // ********************************
    typedef struct {
        logic [7:0]  a;
        logic [31:0] exp;
        logic [31:0] msk;
        bit          chk;
    } camtop_note_t;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, subsys_rst_n;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, ptn_fetch_addr, lfsr_st, q;
    logic [3:0]  avs_byteenable, mem_lat;
    logic        ptn_fetch_req, ptn_fetch_ack, ptn_active, ptn_gen_tick, ptn_to_serial0;
    logic        ptn_sample_10bit, ptn_proc_mode, post0_src_ok;
    logic [2:0]  ptn_lane_count, proc123_src_ok;
    logic [12:0] ptn_frame_width, ptn_frame_height;
    logic [1:0]  proc0_src, post1_src;
    camtop_note_t rd_q[$];
    logic [31:0]  fa_q[$];
    int           err_count, n_compared, n_fetch, cyc, last_tick, exp_gap;
    int           rt[4][5] = '{'{0, 1, 5, 0, 16}, '{1, 2, 3, 1, 24}, '{2, 0, 20, 2, 24},
                               '{3, 3, 0, 0, 32}};

    camtop_ctrl u_camtop_ctrl (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .subsys_rst_n(subsys_rst_n),
        .ptn_fetch_req(ptn_fetch_req), .ptn_fetch_addr(ptn_fetch_addr),
        .ptn_fetch_ack(ptn_fetch_ack), .ptn_active(ptn_active), .ptn_gen_tick(ptn_gen_tick),
        .ptn_to_serial0(ptn_to_serial0), .ptn_lane_count(ptn_lane_count),
        .ptn_sample_10bit(ptn_sample_10bit), .ptn_frame_width(ptn_frame_width),
        .ptn_frame_height(ptn_frame_height), .ptn_proc_mode(ptn_proc_mode),
        .proc0_src(proc0_src), .proc123_src_ok(proc123_src_ok),
        .post0_src_ok(post0_src_ok), .post1_src(post1_src));
    camtop_mem_model u_camtop_mem_model (.clk(clk), .rst_n(rst_n), .fetch_req(ptn_fetch_req),
        .ack_latency(mem_lat), .fetch_ack(ptn_fetch_ack));

    // ********************************
    // helpers
    // ********************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one transfer; an idle edge follows so strobes never toggle twice in a step
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, bit c);
        rd_q.push_back('{a, e & m, m, c});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one pattern run: lane code, divider, delay, repeat field, byte length
    task automatic run(input int ln, dv, dl, rp, input logic [31:0] len);
        int n;
        logic [31:0] base;
        base = lfsr_st;
        wr(OFF_PTN_LENGTH, len);
        wr(OFF_PTN_ADDRESS, base);
        wr(OFF_PTN_CONTROL, (ln << POS_LANE_LO) | (dv << POS_CLKDIV_LO) | dl);
        exp_gap = 1 << dv;
        for (int r = 0; r <= rp; r++) begin
            for (int b = 0; b < len; b += ln + 1) fa_q.push_back(base + b);
        end
        n_fetch = 0;
        wr(OFF_PTN_EN_START, (rp << POS_REPEAT_LO) | 32'h11);
        n = 0;
        while (ptn_fetch_req !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        cmp("start delay", 1, (n + 1 >= dl) && (n < dl + (2 << dv) + 6));
        rd(OFF_PTN_EN_START, 32'h10, 32'h10, 1);
        n = 0;
        do begin
            rd(OFF_PTN_EN_START, 0, 0, 0);
            n++;
        end while (q[4] !== 1'b0 && n < 2000);
        cmp("fetch total", (rp + 1) * len / (ln + 1), n_fetch);
        cmp("fetch left", 0, fa_q.size());
        cmp("start cleared", 0, q & 32'h10);
        cmp("active", 0, ptn_active);
    endtask

    // ********************************
    // clock, monitor and watchdog
    // ********************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // takes the oldest note at each completed read, checks fetch addresses and tick spacing
    always @(posedge clk) begin
        camtop_note_t nt;
        cyc++;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
            nt = rd_q.pop_front();
            if (nt.chk) cmp($sformatf("reg %h", nt.a), nt.exp, avs_readdata & nt.msk);
        end
        if (ptn_fetch_req === 1'b1 && ptn_fetch_ack === 1'b1) begin
            n_fetch++;
            if (fa_q.size() == 0) cmp("fetch count", 0, 1);
            else cmp("fetch addr", fa_q.pop_front(), ptn_fetch_addr);
        end
        if (ptn_active !== 1'b1) last_tick = -1;
        else if (ptn_gen_tick === 1'b1) begin
            if (last_tick >= 0) cmp("tick gap", exp_gap, cyc - last_tick);
            last_tick = cyc;
        end
    end
    initial begin
        #300000;
        err_count++;
        tally_and_finish();
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        logic [31:0] d;
        rst_n = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        ptn_proc_mode = 1'b0;
        mem_lat = 4'h0;
        lfsr_st = 32'hD7E9;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rt[i]) rd(OFF_PTN_CONTROL, RST_PTN_CONTROL, 32'hFFFFFFFF, 1);
        rd(OFF_PTN_LENGTH, RST_ZERO, 32'hFFFFFFFF, 1);
        rd(OFF_POST1_IN, RST_ZERO, 32'hFFFFFFFF, 1);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, BUS_UNMAPPED, 32'hFFFFFFFF, 1);
        wr(OFF_PTN_EN_START, 32'h11);
        rd(OFF_PTN_EN_START, 0, 32'h11, 1);
        cmp("subsys reset", 0, subsys_rst_n);
        cmp("post0 while off", 0, post0_src_ok);
        wr(OFF_TOP_ENABLE, 32'h1);
        @(posedge clk);
        cmp("subsys reset", 1, subsys_rst_n);
        // start with the function off must not fetch
        wr(OFF_PTN_EN_START, 32'h10);
        repeat (60) @(posedge clk);
        cmp("active off", 0, ptn_active);
        wr(OFF_PTN_EN_START, 32'h0);
        // full-width registers, then one byte lane alone
        for (int i = 0; i < 4; i++) begin
            lfsr_st = lfsr_next(lfsr_st);
            wr(OFF_PTN_ADDRESS, lfsr_st);
            rd(OFF_PTN_ADDRESS, lfsr_st, 32'hFFFFFFFF, 1);
            wr(OFF_PTN_LENGTH, ~lfsr_st);
            rd(OFF_PTN_LENGTH, ~lfsr_st, 32'hFFFFFFFF, 1);
        end
        avs_byteenable <= 4'h1;
        wr(OFF_PTN_LENGTH, 32'h000000FF);
        avs_byteenable <= 4'hF;
        rd(OFF_PTN_LENGTH, {~lfsr_st[31:8], 8'hFF}, 32'hFFFFFFFF, 1);
        // frame size shows only in processor mode
        d = lfsr_st & 32'h1FFF1FFF;
        wr(OFF_PTN_FRAME, d);
        repeat (2) @(posedge clk);
        cmp("frame width off", 0, ptn_frame_width);
        ptn_proc_mode <= 1'b1;
        repeat (2) @(posedge clk);
        cmp("frame width", d[12:0], ptn_frame_width);
        cmp("frame height", d[28:16], ptn_frame_height);
        // control decode: lanes, sample width, output port
        for (int i = 0; i < 10; i++) begin
            wr(OFF_PTN_CONTROL, ((i % 2) * 3 << POS_PORT_LO) | (i / 5 << POS_WIDTH_LO)
               | (i % 5 << POS_LANE_LO) | 32'hF);
            @(posedge clk);
            cmp("lanes", (i % 5 < 4) ? i % 5 + 1 : 1, ptn_lane_count);
            cmp("ten bit", i / 5, ptn_sample_10bit);
            cmp("serial0", i % 2 == 0, ptn_to_serial0);
        end
        // every selector code, input two one code apart from the rest
        for (int c = 0; c < 8; c++) begin
            wr(OFF_PROC_IN0, c);
            wr(OFF_PROC_IN1, c);
            wr(OFF_PROC_IN2, c ^ 1);
            wr(OFF_PROC_IN3, c);
            wr(OFF_POST0_IN, c);
            wr(OFF_POST1_IN, c);
            rd(OFF_PROC_IN2, c ^ 1, 32'h7, 1);
            cmp("proc0 src", {c == 4, c == 0}, proc0_src);
            cmp("proc123", {c == 0, c == 1, c == 0}, proc123_src_ok);
            cmp("post0", c == 0, post0_src_ok);
            cmp("post1", {c == 2, c == 0}, post1_src);
        end
        // pattern runs, memory alternating prompt and slow
        foreach (rt[i]) begin
            mem_lat <= (i % 2) ? 4'h3 : 4'h0;
            lfsr_st = lfsr_next(lfsr_st);
            run(rt[i][0], rt[i][1], rt[i][2], rt[i][3], rt[i][4]);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* camtop_mem_model.sv */
// camtop_mem_model: pattern memory that accepts fetch requests
// assumes: requester holds its request until it sees the acknowledge
`timescale 1ns/1ps
`default_nettype none
module camtop_mem_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // fetch handshake
    input  wire logic       fetch_req,
    input  wire logic [3:0] ack_latency,
    output logic            fetch_ack
);
    typedef struct packed {
        logic       ack;
        logic [3:0] cnt;
    } camtop_mem_st_t;
    camtop_mem_st_t st_ff;
    camtop_mem_st_t nxt_st;

    // ack lasts one cycle so a held request is never taken twice
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        if (fetch_req && !st_ff.ack) begin
            if (st_ff.cnt >= ack_latency) begin
                nxt_st.ack = 1'b1;
                nxt_st.cnt = 4'h0;
            end else begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
            end
        end
    end

    // state register, latency counter restarts on reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= {1'b0, 4'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign fetch_ack = st_ff.ack;
endmodule
`default_nettype wire

/* camtop_pkg.sv */
// camtop_pkg: register map, field layout, reset values and codes
// assumes: 32-bit avalon-mm register bus, byte addresses on word boundaries
package camtop_pkg;

    // ********************************
    // register byte offsets
    // ********************************
    localparam logic [7:0] OFF_TOP_ENABLE    = 8'h00;
    localparam logic [7:0] OFF_PTN_EN_START  = 8'h04;
    localparam logic [7:0] OFF_PTN_CONTROL   = 8'h08;
    localparam logic [7:0] OFF_PTN_LENGTH    = 8'h20;
    localparam logic [7:0] OFF_PTN_ADDRESS   = 8'h24;
    localparam logic [7:0] OFF_PTN_FRAME     = 8'h28;
    localparam logic [7:0] OFF_PROC_IN0      = 8'h30;
    localparam logic [7:0] OFF_PROC_IN1      = 8'h34;
    localparam logic [7:0] OFF_PROC_IN2      = 8'h38;
    localparam logic [7:0] OFF_PROC_IN3      = 8'h3C;
    localparam logic [7:0] OFF_POST0_IN      = 8'hA0;
    localparam logic [7:0] OFF_POST1_IN      = 8'hA4;
    localparam logic [7:0] OFF_PTN_STATUS    = 8'hB0;

    // ********************************
    // field positions
    // ********************************
    localparam int POS_FUNC_EN     = 0;
    localparam int POS_RUN_REQ     = 4;
    localparam int POS_REPEAT_LO   = 16;
    localparam int POS_DELAY_LO    = 0;
    localparam int POS_CLKDIV_LO   = 8;
    localparam int POS_LANE_LO     = 16;
    localparam int POS_WIDTH_LO    = 20;
    localparam int POS_PORT_LO     = 24;
    localparam int POS_FRM_W_LO    = 0;
    localparam int POS_FRM_H_LO    = 16;

    // ********************************
    // reset values and codes
    // ********************************
    localparam logic [31:0] RST_PTN_CONTROL = 32'h0000000F;
    localparam logic [31:0] RST_ZERO        = 32'h00000000;
    localparam logic [2:0]  SEL_CODE_000    = 3'h0;
    localparam logic [2:0]  SEL_CODE_010    = 3'h2;
    localparam logic [2:0]  SEL_CODE_100    = 3'h4;
    localparam logic [1:0]  WIDTH_8BIT      = 2'h0;
    localparam logic [1:0]  WIDTH_10BIT     = 2'h1;
    localparam logic [3:0]  LANE_MAX_CODE   = 4'h3;
    localparam logic [2:0]  PORT_SERIAL0    = 3'h0;
    localparam logic [31:0] BUS_UNMAPPED    = 32'h00000000;
endpackage
